// ---- eil_external_irq.sv ----
// external interrupt latch with two pin sources and an ahb-lite register slave
// What this block does
// - low level or falling edge on the dedicated pin sets the request latch
// - a vector-fetch acknowledge pulse clears the request latch
// - writing one to the ack strobe bit clears the latch like a vector fetch
// - reset clears the latch and sensitivity bit even with the pin low
// - level mode: request holds until acknowledged and pin back high, any order
// - edge mode: falling edges only, acknowledge clears at once
// - acknowledge never hides later edges; a new edge latches again
// - mask bit set withholds the request from cpu priority logic
// - pending flag shows the latch regardless of the mask
// - unmasked request makes the cpu take the fixed interrupt vector
// - shared pin is a source only with usb off and its enable set
// - shared enable with usb off forces the shared pin to input with pullup
// - shared source is ORed into the same latch and controls
// - a shared pin event also sets the shared-pin flag
// - break-clear enable on lets ack clear in break; stays cleared after
// - break-clear enable off: ack writes in break leave the latch alone
// - dedicated pin pullup on by default, off while pullup-disable is set
// - shared flag sets on enabled falling edge, clears on option reg read
// - ack strobe is write-only and reads back zero
// - mask bit reads back as written and resets to zero
`timescale 1ns/1ps
module eil_external_irq #(
  parameter int SYNC_STAGES = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [eil_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [eil_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [eil_pkg::DATA_W-1:0] hrdata,
  // pins
  input wire logic irqPinN,
  input wire logic sharedPortPin,
  // system side
  input wire logic vectorAck,
  input wire logic breakState,
  input wire logic breakClearEnable,
  input wire logic usbFunctionEnable,
  output logic cpuIrqReq,
  output logic pinPullupEn,
  output logic sharedPinPullupEn,
  output logic sharedPinForceInput
);

  logic [SYNC_STAGES-1:0] irqSync_reg;
  logic [SYNC_STAGES-1:0] shSync_reg;
  logic irqLevel_reg;
  logic shLevel_reg;
  logic irqLevel_next;
  logic shLevel_next;
  logic mode_reg;
  logic mask_reg;
  logic pud_reg;
  logic sie_reg;
  logic sif_reg;
  logic latch_reg;
  logic ackSeen_reg;
  logic dataWrite_reg;
  logic [eil_pkg::ADDR_W-1:0] dataAddr_reg;
  logic addrPhase;
  logic rdOption;
  logic wrStatus;
  logic wrOption;
  logic shActive;
  logic fallEvent;
  logic shFall;
  logic lowLevel;
  logic setLatch;
  logic swAck;
  logic anyAck;

  // three-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irqSync_reg <= {SYNC_STAGES{eil_pkg::RST_PIN}};
      shSync_reg <= {SYNC_STAGES{eil_pkg::RST_PIN}};
    end
    else
    begin
      irqSync_reg <= {irqSync_reg[SYNC_STAGES-2:0], irqPinN};
      shSync_reg <= {shSync_reg[SYNC_STAGES-2:0], sharedPortPin};
    end
  end

  // a level is accepted only once the last two stages agree
  always_comb
  begin
    irqLevel_next = irqLevel_reg;
    shLevel_next = shLevel_reg;
    if (irqSync_reg[SYNC_STAGES-1] == irqSync_reg[SYNC_STAGES-2])
    begin
      irqLevel_next = irqSync_reg[SYNC_STAGES-1];
    end
    if (shSync_reg[SYNC_STAGES-1] == shSync_reg[SYNC_STAGES-2])
    begin
      shLevel_next = shSync_reg[SYNC_STAGES-1];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irqLevel_reg <= eil_pkg::RST_PIN;
      shLevel_reg <= eil_pkg::RST_PIN;
    end
    else
    begin
      irqLevel_reg <= irqLevel_next;
      shLevel_reg <= shLevel_next;
    end
  end

  // source qualification and event detection
  assign shActive = sie_reg && !usbFunctionEnable;
  assign shFall = shActive && shLevel_reg && !shLevel_next;
  assign fallEvent = (irqLevel_reg && !irqLevel_next) || shFall;
  assign lowLevel = !irqLevel_next || (shActive && !shLevel_next);
  assign setLatch = fallEvent || (mode_reg && lowLevel);

  // ahb-lite address and data phase tracking
  assign addrPhase = hsel && hready && (htrans == eil_pkg::HTRANS_NONSEQ ||
                     htrans == eil_pkg::HTRANS_SEQ);
  assign rdOption = addrPhase && !hwrite && haddr == eil_pkg::OPTION_CONTROL_OFF;
  assign wrStatus = dataWrite_reg && dataAddr_reg == eil_pkg::STATUS_CONTROL_OFF;
  assign wrOption = dataWrite_reg && dataAddr_reg == eil_pkg::OPTION_CONTROL_OFF;

  // protection in break keeps a debugger from eating a pending request
  assign swAck = wrStatus && hwdata[eil_pkg::SC_ACK_BIT] &&
                 (!breakState || breakClearEnable);
  assign anyAck = swAck || vectorAck;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dataWrite_reg <= 1'b0;
      dataAddr_reg <= '0;
    end
    else
    begin
      dataWrite_reg <= addrPhase && hwrite;
      dataAddr_reg <= haddr & ~{{(eil_pkg::ADDR_W-2){1'b0}}, eil_pkg::ADDR_LSB_MASK};
    end
  end

  // software controls
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_reg <= eil_pkg::RST_MODE;
      mask_reg <= eil_pkg::RST_MASK;
      pud_reg <= eil_pkg::RST_PUD;
      sie_reg <= eil_pkg::RST_SIE;
    end
    else
    begin
      if (wrStatus)
      begin
        mode_reg <= hwdata[eil_pkg::SC_MODE_BIT];
        mask_reg <= hwdata[eil_pkg::SC_MASK_BIT];
      end
      if (wrOption)
      begin
        pud_reg <= hwdata[eil_pkg::OC_PUD_BIT];
        sie_reg <= hwdata[eil_pkg::OC_SIE_BIT];
      end
    end
  end

  // request latch; a set in the same cycle as an acknowledge wins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      latch_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
    end
    else if (fallEvent)
    begin
      latch_reg <= 1'b1;
      ackSeen_reg <= 1'b0;
    end
    else if (mode_reg)
    begin
      // level mode needs both the acknowledge and a high pin, either order
      if ((anyAck || ackSeen_reg) && !lowLevel)
      begin
        latch_reg <= 1'b0;
        ackSeen_reg <= 1'b0;
      end
      else
      begin
        latch_reg <= latch_reg || setLatch;
        ackSeen_reg <= (ackSeen_reg || anyAck) && (latch_reg || lowLevel);
      end
    end
    else if (anyAck)
    begin
      latch_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
    end
  end

  // shared-pin flag: set wins over the read that clears it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sif_reg <= 1'b0;
    end
    else if (shFall)
    begin
      sif_reg <= 1'b1;
    end
    else if (rdOption || !sie_reg)
    begin
      sif_reg <= 1'b0;
    end
  end

  // outputs, all registered
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpuIrqReq <= 1'b0;
      pinPullupEn <= 1'b1;
      sharedPinPullupEn <= 1'b0;
      sharedPinForceInput <= 1'b0;
    end
    else
    begin
      // cpu vectors through the fixed slot when this request wins
      cpuIrqReq <= latch_reg && !mask_reg;
      pinPullupEn <= !pud_reg;
      sharedPinPullupEn <= shActive;
      sharedPinForceInput <= shActive;
    end
  end

  // bus answers: zero wait, always okay; read data leaves at the address edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b1;
      hresp <= eil_pkg::HRESP_OKAY;
      hrdata <= eil_pkg::RDATA_ZERO;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= eil_pkg::HRESP_OKAY;
      if (addrPhase && !hwrite)
      begin
        hrdata <= eil_pkg::RDATA_ZERO;
        if (haddr == eil_pkg::STATUS_CONTROL_OFF)
        begin
          hrdata[eil_pkg::SC_MODE_BIT] <= mode_reg;
          hrdata[eil_pkg::SC_MASK_BIT] <= mask_reg;
          hrdata[eil_pkg::SC_ACK_BIT] <= 1'b0;
          hrdata[eil_pkg::SC_PEND_BIT] <= latch_reg;
        end
        else if (haddr == eil_pkg::OPTION_CONTROL_OFF)
        begin
          hrdata[eil_pkg::OC_PUD_BIT] <= pud_reg;
          hrdata[eil_pkg::OC_SIE_BIT] <= sie_reg;
          hrdata[eil_pkg::OC_SIF_BIT] <= sif_reg;
        end
      end
    end
  end

  a_edge_sets: assert property (@(posedge clk) disable iff (!resetn)
    irqLevel_reg && !irqLevel_next |=> latch_reg)
    else $error("falling edge did not set latch");
  a_vector_clears: assert property (@(posedge clk) disable iff (!resetn)
    vectorAck && !mode_reg && !fallEvent |=> !latch_reg)
    else $error("vector ack did not clear latch");
  a_sw_ack_clears: assert property (@(posedge clk) disable iff (!resetn)
    wrStatus && hwdata[eil_pkg::SC_ACK_BIT] && !breakState && !mode_reg && !fallEvent
    |=> !latch_reg)
    else $error("software ack did not clear latch");
  a_level_holds: assert property (@(posedge clk) disable iff (!resetn)
    mode_reg && lowLevel |=> latch_reg)
    else $error("level request dropped while pin low");
  a_level_release: assert property (@(posedge clk) disable iff (!resetn)
    mode_reg && ackSeen_reg && !lowLevel && !fallEvent |=> !latch_reg)
    else $error("level request not released after ack and high pin");
  a_mask_gates: assert property (@(posedge clk) disable iff (!resetn)
    ##1 cpuIrqReq |-> $past(latch_reg) && !$past(mask_reg))
    else $error("request presented while masked or not latched");
  a_pending_view: assert property (@(posedge clk) disable iff (!resetn)
    addrPhase && !hwrite && haddr == eil_pkg::STATUS_CONTROL_OFF
    |=> hrdata[eil_pkg::SC_PEND_BIT] == $past(latch_reg) && !hrdata[eil_pkg::SC_ACK_BIT])
    else $error("pending flag readback wrong");
  // dedicated pin idle and shared source off: nothing may reach the latch or flag
  a_shared_gate: assert property (@(posedge clk) disable iff (!resetn)
    (!sie_reg || usbFunctionEnable) && irqLevel_reg && irqLevel_next && !mode_reg
    && !latch_reg && !sif_reg |=> !latch_reg && !sif_reg)
    else $error("shared pin event while not enabled");
  a_shared_flag: assert property (@(posedge clk) disable iff (!resetn)
    shFall |=> sif_reg && latch_reg)
    else $error("shared event missed flag or latch");
  a_flag_read_clr: assert property (@(posedge clk) disable iff (!resetn)
    rdOption && !shFall |=> !sif_reg)
    else $error("shared flag not cleared by read");
  // an acknowledge remembered before break may still release a level request
  a_break_protect: assert property (@(posedge clk) disable iff (!resetn)
    breakState && !breakClearEnable && !vectorAck && !ackSeen_reg && latch_reg
    |=> latch_reg)
    else $error("latch cleared in protected break");
  a_pullup_follow: assert property (@(posedge clk) disable iff (!resetn)
    ##1 pinPullupEn == !$past(pud_reg))
    else $error("pin pullup does not follow disable bit");
  a_bus_okay: assert property (@(posedge clk) disable iff (!resetn)
    hreadyout && hresp == eil_pkg::HRESP_OKAY)
    else $error("bus answer not ready okay");

endmodule : eil_external_irq

// ---- eil_pkg.sv ----
// constants for the external interrupt latch block
package eil_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] STATUS_CONTROL_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] OPTION_CONTROL_OFF = 8'h1c;
  localparam logic [1:0] ADDR_LSB_MASK = 2'h3;
  // interrupt_status_control fields
  localparam int SC_MODE_BIT = 0;
  localparam int SC_MASK_BIT = 1;
  localparam int SC_ACK_BIT = 2;
  localparam int SC_PEND_BIT = 3;
  // interrupt_option_control fields
  localparam int OC_PUD_BIT = 0;
  localparam int OC_SIE_BIT = 1;
  localparam int OC_SIF_BIT = 2;
  // reset values
  localparam logic RST_MODE = 1'h0;
  localparam logic RST_MASK = 1'h0;
  localparam logic RST_PUD = 1'h0;
  localparam logic RST_SIE = 1'h0;
  localparam logic RST_PIN = 1'h1;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
endpackage : eil_pkg

// ---- eil_pin_driver.sv ----
// model of the board circuitry that drives the two interrupt pins
`timescale 1ns/1ps
module eil_pin_driver (
  // bench commands
  input wire logic irqDriveLow,
  input wire logic sharedDriveLow,
  // pins
  output logic irqPinN,
  output logic sharedPortPin
);
  // board resistors hold both lines high whenever nothing sinks them,
  // so a released line never floats into a false falling edge
  assign irqPinN = irqDriveLow ? 1'h0 : 1'h1;
  assign sharedPortPin = sharedDriveLow ? 1'h0 : 1'h1;
endmodule : eil_pin_driver

// ---- external_interrupt_latch_bench.sv ----
// self-checking bench for the external interrupt latch
`timescale 1ns/1ps
module external_interrupt_latch_bench;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic hsel = 1'h0, hwrite = 1'h0, vectorAck = 1'h0, breakState = 1'h0;
  logic breakClearEnable = 1'h0, usbFunctionEnable = 1'h0, irqLow = 1'h0, shLow = 1'h0;
  logic rdPhase = 1'h0, probeReq = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, cpuIrqReq, pinPullupEn, sharedPinPullupEn, sharedPinForceInput;
  logic irqPinN, sharedPortPin;
  logic [31:0] hrdata;
  logic [31:0] rdQ[$];
  logic [3:0] pinQ[$];
  int errTotal = 0;
  int nTests = 0;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  eil_external_irq DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irqPinN(irqPinN),
    .sharedPortPin(sharedPortPin), .vectorAck(vectorAck), .breakState(breakState),
    .breakClearEnable(breakClearEnable), .usbFunctionEnable(usbFunctionEnable),
    .cpuIrqReq(cpuIrqReq), .pinPullupEn(pinPullupEn), .sharedPinPullupEn(sharedPinPullupEn),
    .sharedPinForceInput(sharedPinForceInput));

  eil_pin_driver pins (.irqDriveLow(irqLow), .sharedDriveLow(shLow), .irqPinN(irqPinN),
    .sharedPortPin(sharedPortPin));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // read data is taken at the data-phase edge, pin outputs one edge after the probe
  always @(posedge clk)
  begin
    if (rdPhase && hreadyout === 1'h1)
      check(hrdata, rdQ.pop_front());
    if (probeReq)
      check({28'h0000000, cpuIrqReq, pinPullupEn, sharedPinPullupEn, sharedPinForceInput},
        {28'h0000000, pinQ.pop_front()});
    if (probeReq)
      check({30'h0, hreadyout, hresp}, {30'h0, 1'h1, eil_pkg::HRESP_OKAY});
  end

  // single word transfer; on a read d is the expected data
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w)
      rdQ.push_back(d);
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= eil_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdPhase <= !w;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rdPhase <= 1'h0;
  endtask : xfer

  task probe(input logic [3:0] e);
    pinQ.push_back(e);
    @(posedge clk);
    probeReq <= 1'h1;
    @(posedge clk);
    probeReq <= 1'h0;
  endtask : probe

  // random low width, then enough edges for the synchroniser and latch
  task pulse(input logic sh);
    @(posedge clk);
    if (sh)
      shLow <= 1'h1;
    else
      irqLow <= 1'h1;
    repeat (4 + $urandom % 8) @(posedge clk);
    shLow <= 1'h0;
    irqLow <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : pulse

  task vack;
    @(posedge clk);
    vectorAck <= 1'h1;
    @(posedge clk);
    vectorAck <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : vack

  task wrapUp;
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrapUp

  initial
  begin
    repeat (20000) @(posedge clk);
    errTotal++;
    wrapUp();
  end

  initial
  begin
    void'($urandom(88276));
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    probe(4'h4);
    xfer(1'h0, 8'h18, 32'h0);
    xfer(1'h0, 8'h1c, 32'h0);
    xfer(1'h0, 8'h04, 32'h0);
    pulse(1'h0);
    probe(4'hc);
    xfer(1'h0, 8'h18, 32'h8);
    vack();
    probe(4'h4);
    xfer(1'h0, 8'h18, 32'h0);
    xfer(1'h1, 8'h18, 32'h2);
    pulse(1'h0);
    probe(4'h4);
    xfer(1'h0, 8'h18, 32'ha);
    xfer(1'h1, 8'h18, 32'h6);
    xfer(1'h0, 8'h18, 32'h2);
    xfer(1'h1, 8'h18, 32'h4);
    pulse(1'h0);
    probe(4'hc);
    xfer(1'h0, 8'h18, 32'h8);
    // level mode: ack while low, then pin high; and the reverse order
    xfer(1'h1, 8'h18, 32'h5);
    irqLow <= 1'h1;
    repeat (6) @(posedge clk);
    vack();
    xfer(1'h0, 8'h18, 32'h9);
    irqLow <= 1'h0;
    repeat (6) @(posedge clk);
    xfer(1'h0, 8'h18, 32'h1);
    pulse(1'h0);
    xfer(1'h0, 8'h18, 32'h9);
    xfer(1'h1, 8'h18, 32'h5);
    xfer(1'h0, 8'h18, 32'h1);
    pulse(1'h0);
    resetn <= 1'h0;
    @(posedge clk);
    resetn <= 1'h1;
    xfer(1'h0, 8'h18, 32'h0);
    // software ack inside break, protected then allowed
    pulse(1'h0);
    breakState <= 1'h1;
    xfer(1'h1, 8'h18, 32'h4);
    xfer(1'h0, 8'h18, 32'h8);
    breakClearEnable <= 1'h1;
    xfer(1'h1, 8'h18, 32'h4);
    breakState <= 1'h0;
    breakClearEnable <= 1'h0;
    xfer(1'h0, 8'h18, 32'h0);
    // shared pin owned by usb, then released to the interrupt
    usbFunctionEnable <= 1'h1;
    xfer(1'h1, 8'h1c, 32'h2);
    probe(4'h4);
    pulse(1'h1);
    xfer(1'h0, 8'h18, 32'h0);
    xfer(1'h0, 8'h1c, 32'h2);
    usbFunctionEnable <= 1'h0;
    repeat (4) @(posedge clk);
    probe(4'h7);
    pulse(1'h1);
    xfer(1'h0, 8'h1c, 32'h6);
    xfer(1'h0, 8'h1c, 32'h2);
    xfer(1'h0, 8'h18, 32'h8);
    vack();
    xfer(1'h1, 8'h1c, 32'h1);
    probe(4'h0);
    xfer(1'h0, 8'h1c, 32'h1);
    wrapUp();
  end
endmodule : external_interrupt_latch_bench
